/* hdl/uart_consts.vh */
// Register map, field positions and reset values of the serial transceiver
`ifndef UART_CONSTS_VH
`define UART_CONSTS_VH

// --------------------------------------------------------------------------
// Register indices; the byte address is four times the index
// --------------------------------------------------------------------------
`define DIV_IDX 6'h09
`define CTRL_IDX 6'h0A
`define STAT_IDX 6'h0B
`define DATA_IDX 6'h0C

// --------------------------------------------------------------------------
// Control register fields
// --------------------------------------------------------------------------
`define CTRL_RXIE 7
`define CTRL_TXIE 6
`define CTRL_EMIE 5
`define CTRL_RXON 4
`define CTRL_TXON 3
`define CTRL_NINE 2
`define CTRL_RX8 1
`define CTRL_TX8 0
`define CTRL_RESET 8'h00

// --------------------------------------------------------------------------
// Status register fields
// --------------------------------------------------------------------------
`define STAT_RXDONE 7
`define STAT_TXDONE 6
`define STAT_EMPTY 5
`define STAT_FRAME 4
`define STAT_OVER 3

// --------------------------------------------------------------------------
// Divisor, oversampling and frame figures; bus response codes
// --------------------------------------------------------------------------
`define DIV_RESET 8'h00
`define OVERSAMPLE 5'h10
`define VOTE_FIRST 4'h8
`define VOTE_MID 4'h9
`define VOTE_LAST 4'hA
`define FRAME_LEN8 4'hA
`define FRAME_LEN9 4'hB
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* hdl/uart_baud_gen.v */
// Baud prescaler: sixteen-times sample tick and bit-rate tick
`timescale 1ns/1ps
`default_nettype none
`include "uart_consts.vh"

module uart_baud_gen #(
	parameter DIV_W = 8
) (
	// Clock and reset
	input wire clk,
	input wire resetn,
	// Divisor from software
	input wire [DIV_W-1:0] divisor,
	// Ticks
	output wire sampleTick,
	output wire bitTick
);

	reg [DIV_W-1:0] preCnt_q;
	reg [3:0] subCnt_q;

	// Prescaler reloads from the divisor at expiry, so a new divisor takes
	// effect at the next expiry without a glitch in the current period
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			preCnt_q <= {DIV_W{1'b0}};
			subCnt_q <= 4'h0;
		end else if (preCnt_q == {DIV_W{1'b0}}) begin
			preCnt_q <= divisor; // [R21]
			subCnt_q <= subCnt_q + 4'h1; // [R15]
		end else begin
			preCnt_q <= preCnt_q - {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end

	// One tick per divisor+1 clocks; bit tick every sixteenth sample tick
	assign sampleTick = (preCnt_q == {DIV_W{1'b0}}); // [R15]
	assign bitTick = sampleTick && (subCnt_q == 4'hF); // [R21]

endmodule // uart_baud_gen
`default_nettype wire

/* hdl/uart_status_control_baud.v */
// Serial transceiver with status, control, data and divisor registers
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "uart_consts.vh"

// Behaviour
// [R1] Transmit-done sets after stop bit has lasted a bit and nothing waits.
// [R2] Transmit-done requests interrupt when enabled; cleared by vector or writing one.
// [R3] Holding-empty sets when byte moves to shifter; clears on data write.
// [R4] Empty interrupt stays asserted while holding-empty set and enabled.
// [R5] Holding-empty reads one during and after reset.
// [R6] Framing error sets on zero stop bit, clears on later good stop.
// [R7] Overrun detected on unread data; shows once older byte is read.
// [R8] Overrun clears when a character transfers without overrun.
// [R9] Status bits two to zero read zero.
// [R10] Three enables gate their flags into requests, only with global enable.
// [R11] Receiver off stops transmit-done, overrun and framing from setting.
// [R12] Transmitter off still finishes shifting and waiting characters.
// [R13] Nine-bit mode sends and receives nine data bits.
// [R14] Received ninth bit read-only; transmit ninth bit write-only.
// [R15] Bit rate is clock over sixteen times divisor plus one.
// [R16] Divisor is an eight-bit read/write register steering the generator.
// [R17] Receiver samples sixteen times per bit, majority of middle samples.
// [R18] Start bit on tick after load, data LSB first, then stop.
// [R19] Every received character goes to data register and sets receive-done; the code drops a character that overruns unread data instead.
// [R20] Reading data register clears receive-done.
// [R21] Prescaler reloads from divisor; divide by sixteen gives bit clock.
module uart_status_control_baud #(
	parameter ADDR_W = 8
) (
	// Clock and reset
	input wire clk,
	input wire resetn,
	// AXI4-Lite write channels
	input wire [ADDR_W-1:0] awaddr,
	input wire awvalid,
	output wire awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output wire wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	// AXI4-Lite read channels
	input wire [ADDR_W-1:0] araddr,
	input wire arvalid,
	output wire arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	// Serial pins
	input wire serialIn,
	output reg serialOut,
	// Interrupt controller side
	input wire globalIrqEn,
	input wire txDoneVecTaken,
	output wire rxDoneIrq,
	output wire txDoneIrq,
	output wire txEmptyIrq
);

	// --------------------------------------------------------------------
	// State codes
	// --------------------------------------------------------------------
	localparam TX_IDLE = 2'b01;
	localparam TX_RUN = 2'b10;
	localparam RX_IDLE = 3'b001;
	localparam RX_BITS = 3'b010;
	localparam RX_DONE = 3'b100;

	// --------------------------------------------------------------------
	// Declarations
	// --------------------------------------------------------------------
	reg [7:0] ctrl_q;
	reg [7:0] div_q;
	reg txDone_q;
	reg holdFull_q;
	reg [7:0] txHold_q;
	reg [1:0] txState_q;
	reg [10:0] txShift_q;
	reg [3:0] txCnt_q;
	reg rxDone_q;
	reg frame_q;
	reg over_q;
	reg overPend_q;
	reg [7:0] rxData_q;
	reg rxNinth_q;
	reg [2:0] rxState_q;
	reg [3:0] sCnt_q;
	reg [1:0] votes_q;
	reg [3:0] rxIdx_q;
	reg [8:0] rxShift_q;
	reg rxStop_q;
	reg inMeta_q;
	reg inSync_q;
	reg awHeld_q;
	reg wHeld_q;
	reg [ADDR_W-1:0] awAddr_q;
	reg [31:0] wData_q;
	reg [3:0] wStrb_q;
	wire sampleTick;
	wire bitTick;
	wire doWrite;
	wire [5:0] wIdx;
	wire [5:0] rIdx;
	wire lane0;
	wire dataWr;
	wire statWr;
	wire dataRd;
	wire nineMode;
	wire [10:0] txFrame;
	wire [3:0] frameLen;
	wire txLoadIdle;
	wire txEndTick;
	wire rxOn;
	wire voteBit;
	wire [1:0] votesNow;
	wire [3:0] lastIdx;
	wire rxFinish;
	wire rxOverrun;
	reg [31:0] rdMux;
	reg rdHit;

	// --------------------------------------------------------------------
	// Baud generator
	// --------------------------------------------------------------------
	uart_baud_gen #(
		.DIV_W(8)
	) baudGen (
		.clk(clk),
		.resetn(resetn),
		.divisor(div_q),
		.sampleTick(sampleTick),
		.bitTick(bitTick)
	);

	// --------------------------------------------------------------------
	// Bus slave: write path
	// --------------------------------------------------------------------
	// Address and data may arrive in either order; each is held until both
	assign awready = !awHeld_q && !bvalid;
	assign wready = !wHeld_q && !bvalid;
	assign doWrite = awHeld_q && wHeld_q && !bvalid;
	assign wIdx = awAddr_q[7:2];
	assign lane0 = wStrb_q[0];
	assign dataWr = doWrite && lane0 && (wIdx == `DATA_IDX);
	assign statWr = doWrite && lane0 && (wIdx == `STAT_IDX);

	// Capture channels and issue the response one cycle after the write
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= {ADDR_W{1'b0}};
			wData_q <= 32'h00000000;
			wStrb_q <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= awaddr;
			end
			if (wvalid && wready) begin
				wHeld_q <= 1'b1;
				wData_q <= wdata;
				wStrb_q <= wstrb;
			end
			if (doWrite) begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				bvalid <= 1'b1;
				if (wIdx == `DIV_IDX || wIdx == `CTRL_IDX || wIdx == `STAT_IDX ||
					wIdx == `DATA_IDX) begin
					bresp <= `RESP_OKAY;
				end else begin
					bresp <= `RESP_SLVERR;
				end
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Software-written registers; the received ninth bit is not stored here
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= `CTRL_RESET;
			div_q <= `DIV_RESET;
		end else if (doWrite && lane0) begin
			if (wIdx == `CTRL_IDX) begin
				ctrl_q <= wData_q[7:0];
			end else if (wIdx == `DIV_IDX) begin
				div_q <= wData_q[7:0]; // [R16]
			end
		end
	end

	// --------------------------------------------------------------------
	// Bus slave: read path
	// --------------------------------------------------------------------
	assign arready = !rvalid;
	assign rIdx = araddr[7:2];
	assign dataRd = arvalid && arready && (rIdx == `DATA_IDX);

	// Read decode; write-only ninth bit and low status bits read zero
	always @* begin
		rdMux = 32'h00000000;
		rdHit = 1'b1;
		if (rIdx == `CTRL_IDX) begin
			rdMux[7:0] = {ctrl_q[7:2], rxNinth_q, 1'b0}; // [R14]
		end else if (rIdx == `STAT_IDX) begin
			rdMux[7:0] = {rxDone_q, txDone_q, !holdFull_q, frame_q, over_q, 3'b000}; // [R9]
		end else if (rIdx == `DATA_IDX) begin
			rdMux[7:0] = rxData_q;
		end else if (rIdx == `DIV_IDX) begin
			rdMux[7:0] = div_q; // [R16]
		end else begin
			rdHit = 1'b0;
		end
	end

	// Read data is registered, answer one cycle after the address
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= rdMux;
			rresp <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// --------------------------------------------------------------------
	// Interrupt requests
	// --------------------------------------------------------------------
	assign rxDoneIrq = globalIrqEn && ctrl_q[`CTRL_RXIE] && rxDone_q; // [R10]
	assign txDoneIrq = globalIrqEn && ctrl_q[`CTRL_TXIE] && txDone_q; // [R2] [R10]
	// Level request: repeats until software refills the holding register
	assign txEmptyIrq = globalIrqEn && ctrl_q[`CTRL_EMIE] && !holdFull_q; // [R4] [R10]

	// --------------------------------------------------------------------
	// Transmitter
	// --------------------------------------------------------------------
	assign nineMode = ctrl_q[`CTRL_NINE];
	assign rxOn = ctrl_q[`CTRL_RXON];
	// Frame: start at bit 0, data LSB first, optional ninth bit, stop
	assign txFrame = nineMode ? {1'b1, ctrl_q[`CTRL_TX8], txHold_q, 1'b0} :
		{2'b11, txHold_q, 1'b0}; // [R13]
	assign frameLen = nineMode ? `FRAME_LEN9 : `FRAME_LEN8;
	// A fresh start needs the enable; a running frame chains regardless
	assign txLoadIdle = (txState_q == TX_IDLE) && holdFull_q && ctrl_q[`CTRL_TXON];
	assign txEndTick = (txState_q == TX_RUN) && bitTick && (txCnt_q == 4'h0);

	// Shifter and line driver
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			txState_q <= TX_IDLE;
			txShift_q <= 11'h7FF;
			txCnt_q <= 4'h0;
			serialOut <= 1'b1;
		end else begin
			case (txState_q)
			TX_IDLE: begin
				serialOut <= 1'b1;
				if (txLoadIdle) begin
					txShift_q <= txFrame;
					txCnt_q <= frameLen;
					txState_q <= TX_RUN;
				end
			end
			TX_RUN: begin
				if (bitTick) begin
					if (txCnt_q != 4'h0) begin
						serialOut <= txShift_q[0]; // [R18]
						txShift_q <= {1'b1, txShift_q[10:1]};
						txCnt_q <= txCnt_q - 4'h1;
					end else if (holdFull_q) begin
						// Stop bit done and a byte waits: start it at once
						serialOut <= 1'b0; // [R12] [R18]
						txShift_q <= {1'b1, txFrame[10:1]};
						txCnt_q <= frameLen - 4'h1;
					end else begin
						txState_q <= TX_IDLE;
					end
				end
			end
			default: begin
				txState_q <= TX_IDLE;
			end
			endcase
		end
	end

	// Holding register; a write in the load cycle keeps it full
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			holdFull_q <= 1'b0; // [R5]
			txHold_q <= 8'h00;
		end else if (dataWr) begin
			holdFull_q <= 1'b1; // [R3]
			txHold_q <= wData_q[7:0];
		end else if (txLoadIdle || (txEndTick && holdFull_q)) begin
			holdFull_q <= 1'b0; // [R3]
		end
	end

	// Transmit-done: set wins over vector and software clear
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			txDone_q <= 1'b0;
		end else if (txEndTick && !holdFull_q && !dataWr && rxOn) begin
			txDone_q <= 1'b1; // [R1] [R11]
		end else if (txDoneVecTaken || (statWr && wData_q[`STAT_TXDONE])) begin
			txDone_q <= 1'b0; // [R2]
		end
	end

	// --------------------------------------------------------------------
	// Receiver
	// --------------------------------------------------------------------
	// Line synchroniser
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			inMeta_q <= 1'b1;
			inSync_q <= 1'b1;
		end else begin
			inMeta_q <= serialIn;
			inSync_q <= inMeta_q;
		end
	end

	assign votesNow = votes_q + {1'b0, inSync_q};
	assign voteBit = votesNow[1]; // [R17]
	assign lastIdx = nineMode ? 4'hA : 4'h9; // [R13]

	// Sample counter starts at 1 on the first zero; votes at 8, 9 and 10
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rxState_q <= RX_IDLE;
			sCnt_q <= 4'h0;
			votes_q <= 2'b00;
			rxIdx_q <= 4'h0;
			rxShift_q <= 9'h000;
			rxStop_q <= 1'b1;
		end else if (!rxOn) begin
			rxState_q <= RX_IDLE;
		end else begin
			case (rxState_q)
			RX_IDLE: begin
				if (sampleTick && !inSync_q) begin
					sCnt_q <= 4'h1; // [R17]
					votes_q <= 2'b00;
					rxIdx_q <= 4'h0;
					rxState_q <= RX_BITS;
				end
			end
			RX_BITS: begin
				if (sampleTick) begin
					sCnt_q <= sCnt_q + 4'h1;
					if (sCnt_q == `VOTE_FIRST - 4'h1 || sCnt_q == `VOTE_MID - 4'h1) begin
						votes_q <= votesNow;
					end else if (sCnt_q == `VOTE_LAST - 4'h1) begin
						votes_q <= 2'b00;
						rxIdx_q <= rxIdx_q + 4'h1;
						if (rxIdx_q == 4'h0) begin
							// Noise spike: a start bit that votes one is rejected
							if (voteBit) begin
								rxState_q <= RX_IDLE;
							end
						end else if (rxIdx_q == lastIdx) begin
							rxStop_q <= voteBit;
							rxState_q <= RX_DONE;
						end else begin
							rxShift_q <= {voteBit, rxShift_q[8:1]};
						end
					end
				end
			end
			RX_DONE: begin
				rxState_q <= RX_IDLE;
			end
			default: begin
				rxState_q <= RX_IDLE;
			end
			endcase
		end
	end

	assign rxFinish = (rxState_q == RX_DONE) && rxOn;
	// A read in the same cycle frees the data register in time
	assign rxOverrun = rxFinish && rxDone_q && !dataRd; // [R7]

	// Data transfer and receive flags; sets win over the read clear
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rxDone_q <= 1'b0;
			rxData_q <= 8'h00;
			rxNinth_q <= 1'b0;
			frame_q <= 1'b0;
			over_q <= 1'b0;
			overPend_q <= 1'b0;
		end else begin
			if (rxFinish && !rxOverrun) begin
				rxDone_q <= 1'b1; // [R19]
				rxData_q <= nineMode ? rxShift_q[7:0] : rxShift_q[8:1];
				rxNinth_q <= nineMode ? rxShift_q[8] : rxNinth_q; // [R13] [R14]
				frame_q <= !rxStop_q; // [R6] [R11]
				over_q <= 1'b0; // [R8]
				overPend_q <= 1'b0;
			end else begin
				if (dataRd) begin
					rxDone_q <= 1'b0; // [R20]
					over_q <= overPend_q; // [R7]
					overPend_q <= 1'b0;
				end
				if (rxOverrun) begin
					overPend_q <= 1'b1; // [R7] [R11]
				end
			end
		end
	end

endmodule // uart_status_control_baud
`default_nettype wire

/* dv/uart_status_control_baud_checker.sv */
// Concurrent checks on the serial transceiver's ports
`timescale 1ns/1ps
`default_nettype none
`include "uart_consts.vh"
module uart_status_control_baud_checker #(
	parameter ADDR_W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Bus signals
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic awvalid,
	// Line and interrupts
	input wire logic serialOut,
	input wire logic globalIrqEn,
	input wire logic txDoneVecTaken,
	input wire logic rxDoneIrq,
	input wire logic txDoneIrq,
	input wire logic txEmptyIrq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [ADDR_W-1:0] arLast_q;
	int lowRun_q;
	// Address of the read in flight; length of the running low level on the line
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			arLast_q <= '0;
			lowRun_q <= 0;
		end else begin
			if (arvalid && arready)
				arLast_q <= araddr;
			lowRun_q <= serialOut ? 0 : lowRun_q + 1;
		end
	end
	// A write still in flight may clear flags one cycle late, so both cycles count
	sequence dataRead;
		arvalid && arready && araddr == {`DATA_IDX, 2'b00};
	endsequence
	sequence writeQuiet;
		!awvalid && !$past(awvalid);
	endsequence
	AST_STAT_LOW: assert property (
		$rose(rvalid) && arLast_q == {`STAT_IDX, 2'b00} |-> rdata[2:0] == 3'h0)
		else $error("Reserved status bits read nonzero");
	AST_RX_GATE: assert property (rxDoneIrq |-> globalIrqEn)
		else $error("Receive request without global enable");
	AST_TX_GATE: assert property (txDoneIrq |-> globalIrqEn)
		else $error("Transmit-done request without global enable");
	AST_EMPTY_GATE: assert property (txEmptyIrq |-> globalIrqEn)
		else $error("Empty request without global enable");
	AST_BIT_LEN: assert property (
		$rose(serialOut) |-> lowRun_q != 0 && lowRun_q % 16 == 0)
		else $error("Low run on line not a whole number of bits");
	AST_VEC_CLEAR: assert property (txDoneVecTaken && txDoneIrq |=> !txDoneIrq)
		else $error("Vector taken did not clear transmit-done");
	AST_EMPTY_HOLD: assert property (
		txEmptyIrq ##0 writeQuiet |=> txEmptyIrq || !globalIrqEn)
		else $error("Empty request dropped without a write");
	AST_RX_READ: assert property (dataRead ##0 rxDoneIrq |=> !rxDoneIrq)
		else $error("Data read did not clear receive-done");
	AST_DONE_LINE: assert property (
		$rose(txDoneIrq) && $stable(globalIrqEn) |->
		serialOut && $past(serialOut, 8) && $past(serialOut, 15))
		else $error("Transmit-done before stop bit completed");
endmodule // uart_status_control_baud_checker
bind uart_status_control_baud uart_status_control_baud_checker #(.ADDR_W(ADDR_W)) chk (
	.clk(clk), .resetn(resetn), .araddr(araddr), .arvalid(arvalid), .arready(arready),
	.rdata(rdata), .rvalid(rvalid), .awvalid(awvalid), .serialOut(serialOut),
	.globalIrqEn(globalIrqEn), .txDoneVecTaken(txDoneVecTaken), .rxDoneIrq(rxDoneIrq),
	.txDoneIrq(txDoneIrq), .txEmptyIrq(txEmptyIrq));
`default_nettype wire

/* dv/uart_remote_peer.sv */
// Remote serial peer: frame sender and decoder
`timescale 1ns/1ps
`default_nettype none
module uart_remote_peer (
	// Clock
	input wire logic clk,
	// Serial lines
	output logic serialIn,
	input wire logic serialOut
);
	int bitLen = 16;
	bit nine = 0;
	logic [8:0] rxData;
	logic [8:0] rxQ[$];
	initial serialIn = 1'b1;
	// Start, data LSB first, stop, then idle bits so the receiver settles: two in eight-bit mode, one in nine-bit mode
	task automatic send(input logic [8:0] d, input logic stopBit);
		logic [11:0] f;
		f = nine ? {1'b1, stopBit, d, 1'b0} : {2'b11, stopBit, d[7:0], 1'b0};
		for (int i = 0; i < 12; i++) begin
			serialIn <= f[i];
			repeat (bitLen) @(posedge clk);
		end
	endtask
	// Mid-bit decoder; a wrong bit rate shows up as wrong data
	initial begin
		forever begin
			@(negedge serialOut);
			rxData = '0;
			repeat (bitLen / 2) @(posedge clk);
			for (int i = 0; i < (nine ? 9 : 8); i++) begin
				repeat (bitLen) @(posedge clk);
				rxData[i] = serialOut;
			end
			repeat (bitLen) @(posedge clk);
			rxQ.push_back(rxData);
		end
	end
endmodule // uart_remote_peer
`default_nettype wire

/* dv/uart_status_control_baud_tb.sv */
// Self-checking bench of the serial transceiver
`timescale 1ns/1ps
`default_nettype none
`include "uart_consts.vh"
module uart_status_control_baud_tb;
	localparam logic [7:0] A_DIV = {`DIV_IDX, 2'b00};
	localparam logic [7:0] A_CTRL = {`CTRL_IDX, 2'b00};
	localparam logic [7:0] A_STAT = {`STAT_IDX, 2'b00};
	localparam logic [7:0] A_DATA = {`DATA_IDX, 2'b00};
	logic clk = 0;
	logic resetn = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, d;
	logic [3:0] wstrb = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, serialIn, serialOut;
	logic [1:0] bresp, rresp, r;
	logic globalIrqEn = 0, txDoneVecTaken = 0, rxDoneIrq, txDoneIrq, txEmptyIrq;
	int nMismatch = 0, testsRun = 0, cycles = 0;
	uart_status_control_baud dut (.clk, .resetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .serialIn, .serialOut, .globalIrqEn,
		.txDoneVecTaken, .rxDoneIrq, .txDoneIrq, .txEmptyIrq);
	uart_remote_peer pr (.clk(clk), .serialIn(serialIn), .serialOut(serialOut));
	initial begin
		forever #2.5 clk = ~clk;
	end
	// Hang guard: far above the few thousand cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			nMismatch++;
			testDone();
		end
	end
	task automatic testDone();
		if (nMismatch == 0 && testsRun > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		testsRun++;
		if (got !== e) begin
			nMismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, e);
		end
	endtask
	// Bus write; handshakes are judged at the falling edge, acted on at the next rise
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic aw, w, b;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, v};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			aw = awready;
			w = wready;
			b = bvalid;
			r = bresp;
			@(posedge clk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end while (!b);
		bready <= 1'b0;
	endtask
	// Bus read returning data and response
	task automatic rd(input logic [7:0] a);
		logic ar, v;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			ar = arready;
			v = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ar) arvalid <= 1'b0;
		end while (!v);
		rready <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk(d & m, e);
	endtask
	// Bounded wait for the peer to decode one more character
	task automatic waitTx(input logic [8:0] e);
		for (int i = 0; i < 4000 && pr.rxQ.size() == 0; i++) @(posedge clk);
		chk(pr.rxQ.size() ? pr.rxQ.pop_front() : 32'hFFFF, e);
	endtask
	task automatic tReset();
		rc(A_STAT, 32'hFFFFFFFF, 32'h20);
		wr(8'h3C, 8'hFF);
		chk(r, `RESP_SLVERR);
		rc(A_CTRL, 32'hFF, 32'h00);
		rc(A_DIV, 32'hFF, 32'h00);
		rd(8'h3C);
		chk(r, `RESP_SLVERR);
	endtask
	task automatic tDivisor();
		wr(A_DIV, 8'hA5);
		chk(r, `RESP_OKAY);
		rc(A_DIV, 32'hFF, 32'hA5);
		wr(A_DIV, 8'h01);
		pr.bitLen = 32;
		wr(A_CTRL, 8'h08);
		wr(A_DATA, 8'h96);
		waitTx(9'h096);
		repeat (80) @(posedge clk);
		rc(A_STAT, 32'h40, 32'h00);
		wr(A_DIV, 8'h00);
		pr.bitLen = 16;
	endtask
	task automatic tTransmit();
		wr(A_CTRL, 8'h78);
		globalIrqEn <= 1'b1;
		@(negedge clk);
		chk(txEmptyIrq, 1'b1);
		wr(A_DATA, 8'h5A);
		wr(A_DATA, 8'hC3);
		rc(A_STAT, 32'h20, 32'h00);
		wr(A_CTRL, 8'h70);
		waitTx(9'h05A);
		waitTx(9'h0C3);
		repeat (24) @(posedge clk);
		rc(A_STAT, 32'h60, 32'h60);
		@(negedge clk);
		chk(txDoneIrq, 1'b1);
		@(posedge clk);
		globalIrqEn <= 1'b0;
		@(negedge clk);
		chk({txDoneIrq, txEmptyIrq}, 2'b00);
		@(posedge clk);
		globalIrqEn <= 1'b1;
		@(posedge clk);
		txDoneVecTaken <= 1'b1;
		@(posedge clk);
		txDoneVecTaken <= 1'b0;
		@(negedge clk);
		chk(txDoneIrq, 1'b0);
	endtask
	task automatic tReceive();
		wr(A_CTRL, 8'h90);
		pr.send(9'h03C, 1'b1);
		@(negedge clk);
		chk(rxDoneIrq, 1'b1);
		rc(A_DATA, 32'hFF, 32'h3C);
		@(negedge clk);
		chk(rxDoneIrq, 1'b0);
		pr.send(9'h081, 1'b0);
		rc(A_STAT, 32'h90, 32'h90);
		rc(A_DATA, 32'hFF, 32'h81);
		pr.send(9'h07E, 1'b1);
		rc(A_STAT, 32'h10, 32'h00);
		rd(A_DATA);
		pr.send(9'h011, 1'b1);
		pr.send(9'h022, 1'b1);
		rc(A_STAT, 32'h08, 32'h00);
		rc(A_DATA, 32'hFF, 32'h11);
		rc(A_STAT, 32'h08, 32'h08);
		pr.send(9'h033, 1'b1);
		rc(A_STAT, 32'h08, 32'h00);
		rc(A_DATA, 32'hFF, 32'h33);
		wr(A_CTRL, 8'h00);
		pr.send(9'h055, 1'b0);
		rc(A_STAT, 32'hD8, 32'h00);
	endtask
	task automatic tNine();
		wr(A_CTRL, 8'h5D);
		pr.nine = 1;
		rc(A_CTRL, 32'h01, 32'h00);
		wr(A_DATA, 8'h33);
		waitTx(9'h133);
		pr.send(9'h1AA, 1'b1);
		rc(A_CTRL, 32'h02, 32'h02);
		rc(A_DATA, 32'hFF, 32'hAA);
		rc(A_STAT, 32'h40, 32'h40);
		wr(A_STAT, 8'h40);
		rc(A_STAT, 32'h40, 32'h00);
		pr.nine = 0;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		tReset();
		tDivisor();
		tTransmit();
		tReceive();
		tNine();
		testDone();
	end
endmodule // uart_status_control_baud_tb
`default_nettype wire
